//--- logic/swip_pkg.sv
// Purpose: Shared constants for the switch ingress policing block.
// Assumes: 100 MHz core clock, 32-bit APB register access.
// Notes: Offsets are byte addresses of word-aligned registers.
package swip_pkg;
  localparam int unsigned SWIP_CLK_NS = 10;
  localparam int unsigned SWIP_STEP_NS = 20;
  localparam int unsigned SWIP_STEP_CYC = SWIP_STEP_NS / SWIP_CLK_NS;
  localparam int unsigned SWIP_BCAST_WIN_US = 1720;
  localparam int unsigned SWIP_BCAST_WIN_CYC = SWIP_BCAST_WIN_US * 1000 / SWIP_CLK_NS;
  localparam int unsigned SWIP_NSTREAM = 24;
  localparam logic [13:0] SWIP_CIR_MIN = 14'h0003;
  localparam logic [15:0] SWIP_BUCKET_RST = 16'h0600;
  localparam logic [5:0] SWIP_BC_UNIT_SH = 6'h06;
  localparam logic [7:0] SWIP_IGMP_PROTO = 8'h02;
  localparam logic [11:0] SWIP_VID_RSVD = 12'hFFF;
  // Register byte offsets.
  localparam logic [11:0] SWIP_OFF_RATE_CFG = 12'h000;
  localparam logic [11:0] SWIP_OFF_RATE_CMD = 12'h004;
  localparam logic [11:0] SWIP_OFF_RATE_WDATA = 12'h008;
  localparam logic [11:0] SWIP_OFF_BC_THROT = 12'h00C;
  localparam logic [11:0] SWIP_OFF_BC_CAP = 12'h010;
  localparam logic [11:0] SWIP_OFF_GLB_CFG = 12'h014;
  localparam logic [11:0] SWIP_OFF_MIRROR = 12'h018;
  localparam logic [11:0] SWIP_OFF_BUFFER_MANAGER_CONFIG_REG = 12'h01C;
  localparam logic [11:0] SWIP_OFF_STATUS = 12'h020;
  // Command register fields.
  localparam int unsigned SWIP_CMD_GO_BIT = 31;
  localparam logic [1:0] SWIP_CMD_SEL_CIR = 2'h0;
  localparam logic [1:0] SWIP_CMD_SEL_CBS = 2'h1;
  localparam logic [1:0] SWIP_CMD_SEL_EBS = 2'h2;
  // Rate modes.
  localparam logic [1:0] SWIP_MODE_PORT = 2'h0;
  localparam logic [1:0] SWIP_MODE_PRI = 2'h1;
  localparam logic [1:0] SWIP_MODE_PORT_PRI = 2'h2;
  // Packet colors.
  localparam logic [1:0] SWIP_GREEN = 2'h0;
  localparam logic [1:0] SWIP_YELLOW = 2'h1;
  localparam logic [1:0] SWIP_RED = 2'h2;
  // Reset values.
  localparam logic [9:0] SWIP_BC_CAP_RST = 10'h0FF;
  localparam logic [13:0] SWIP_CIR_RST = 14'h0000;
endpackage

//--- logic/swip_policer.sv
// Purpose: Ingress metering, broadcast throttling, IGMP trap and mirroring.
// Assumes: One packet descriptor per pkt_valid pulse, decision one cycle later.
// Notes: Registers reached over APB; all outputs come from flip-flops.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module swip_policer #(
  parameter int unsigned BCAST_WIN_CYC = swip_pkg::SWIP_BCAST_WIN_CYC
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Packet descriptor from the receive path and lookup.
  input wire logic pkt_valid,
  input wire logic [1:0] pkt_port,
  input wire logic [10:0] pkt_len,
  input wire logic [2:0] pkt_dest,
  input wire logic pkt_filtered,
  input wire logic pkt_bcast,
  input wire logic pkt_multi,
  input wire logic pkt_mcast,
  input wire logic pkt_ipv4,
  input wire logic pkt_ipv6,
  input wire logic [7:0] pkt_ip_proto,
  input wire logic [7:0] pkt_tos,
  input wire logic [2:0] pkt_diffserv_pri,
  input wire logic pkt_tagged,
  input wire logic [11:0] pkt_vid,
  input wire logic [2:0] pkt_vlan_pri,
  input wire logic pkt_member,
  // Switch state from elsewhere.
  input wire logic [2:0] port_forwarding,
  input wire logic [9:0] bcast_buf_used,
  // Decision to the buffer manager.
  output logic dec_valid,
  output logic [2:0] dec_dest,
  output logic dec_drop,
  output logic [1:0] dec_color,
  output logic [4:0] dec_stream,
  output logic dec_rnd_discard
);
  localparam int unsigned NS = swip_pkg::SWIP_NSTREAM;

  // Configuration registers.
  logic rate_en_r;
  logic [1:0] rate_mode_r;
  logic [31:0] wdata_r;
  logic [13:0] cir_r [NS];
  logic [15:0] cbs_r;
  logic [15:0] ebs_r;
  logic [23:0] bc_lvl_r;
  logic [2:0] bc_en_r;
  logic [9:0] bc_cap_r;
  logic [22:0] glb_r;
  logic [7:0] mir_r;
  logic [1:0] bm_r;
  logic [15:0] cb_r [NS];
  logic [15:0] eb_r [NS];
  logic [14:0] tmr_r [NS];
  logic [17:0] win_r;
  logic [15:0] bc_cnt_r [3];
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic dec_valid_r;
  logic [2:0] dec_dest_r;
  logic dec_drop_r;
  logic [1:0] dec_color_r;
  logic [4:0] dec_stream_r;
  logic dec_rnd_r;

  // Global ingress configuration fields.
  wire igmp_en = glb_r[0];
  wire igmp_echo = glb_r[1];
  wire [1:0] mon_port = glb_r[3:2];
  wire vlan_en = glb_r[4];
  wire [2:0] admit_only_vlan = glb_r[7:5];
  wire mem_check = glb_r[8];
  wire admit_nonmem = glb_r[9];
  wire state_ovr = glb_r[10];
  wire use_ip = glb_r[11];
  wire use_prec = glb_r[12];
  wire vlan_higher = glb_r[13];
  wire [8:0] def_pri = glb_r[22:14];
  // Mirroring fields: the sniffer is one encoded port, so only one can exist.
  wire rx_mir_en = mir_r[0];
  wire tx_mir_en = mir_r[1];
  wire [2:0] mirrored = mir_r[4:2];
  wire [1:0] sniffer = mir_r[6:5];
  wire mir_filt_en = mir_r[7];
  wire drop_yel = bm_r[1];

  // APB decode.
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready_r & pwrite;
  wire [11:0] a = paddr;
  wire hit_cfg = a == swip_pkg::SWIP_OFF_RATE_CFG;
  wire hit_cmd = a == swip_pkg::SWIP_OFF_RATE_CMD;
  wire hit_wd = a == swip_pkg::SWIP_OFF_RATE_WDATA;
  wire hit_bt = a == swip_pkg::SWIP_OFF_BC_THROT;
  wire hit_cap = a == swip_pkg::SWIP_OFF_BC_CAP;
  wire hit_glb = a == swip_pkg::SWIP_OFF_GLB_CFG;
  wire hit_mir = a == swip_pkg::SWIP_OFF_MIRROR;
  wire hit_bm = a == swip_pkg::SWIP_OFF_BUFFER_MANAGER_CONFIG_REG;
  wire hit_st = a == swip_pkg::SWIP_OFF_STATUS;
  wire hit_any = hit_cfg | hit_cmd | hit_wd | hit_bt | hit_cap | hit_glb | hit_mir | hit_bm
    | hit_st;
  wire [31:0] rd_mux =
    hit_cfg ? {29'h0, rate_mode_r, rate_en_r} :
    hit_wd ? wdata_r :
    hit_bt ? {5'h0, bc_en_r, bc_lvl_r} :
    hit_cap ? {22'h0, bc_cap_r} :
    hit_glb ? {9'h0, glb_r} :
    hit_mir ? {24'h0, mir_r} :
    hit_bm ? {30'h0, bm_r} :
    hit_st ? {25'h0, dec_stream_r, dec_color_r} : 32'h0;
  wire cmd_go = apb_wr & hit_cmd & pwdata[swip_pkg::SWIP_CMD_GO_BIT];
  wire [4:0] cmd_idx = pwdata[4:0];
  wire [1:0] cmd_sel = pwdata[9:8];

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
      prdata_r <= 32'h0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= apb_setup;
      prdata_r <= apb_setup ? rd_mux : 32'h0;
      pslverr_r <= apb_setup & ~hit_any;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rate_en_r <= 1'b0;
      rate_mode_r <= swip_pkg::SWIP_MODE_PORT;
      wdata_r <= 32'h0;
      cbs_r <= swip_pkg::SWIP_BUCKET_RST;
      ebs_r <= swip_pkg::SWIP_BUCKET_RST;
      bc_lvl_r <= 24'h0;
      bc_en_r <= 3'h0;
      bc_cap_r <= swip_pkg::SWIP_BC_CAP_RST;
      glb_r <= 23'h0;
      mir_r <= 8'h0;
      bm_r <= 2'h0;
    end else if (apb_wr) begin
      if (hit_cfg) begin
        rate_en_r <= pwdata[0];
        rate_mode_r <= pwdata[2:1];
      end
      if (hit_wd) begin
        wdata_r <= pwdata;
      end
      // Shared burst limits take effect at once, no reset needed.
      if (cmd_go && cmd_sel == swip_pkg::SWIP_CMD_SEL_CBS) begin
        cbs_r <= wdata_r[15:0];
      end
      if (cmd_go && cmd_sel == swip_pkg::SWIP_CMD_SEL_EBS) begin
        ebs_r <= wdata_r[15:0];
      end
      if (hit_bt) begin
        bc_lvl_r <= pwdata[23:0];
        bc_en_r <= pwdata[26:24];
      end
      if (hit_cap) begin
        bc_cap_r <= pwdata[9:0];
      end
      if (hit_glb) begin
        glb_r <= pwdata[22:0];
      end
      if (hit_mir) begin
        mir_r <= pwdata[7:0];
      end
      if (hit_bm) begin
        bm_r <= pwdata[1:0];
      end
    end
  end

  // Per-stream committed rate, written through the command pair.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NS; i++) begin
        cir_r[i] <= swip_pkg::SWIP_CIR_RST;
      end
    end else if (cmd_go && cmd_sel == swip_pkg::SWIP_CMD_SEL_CIR && cmd_idx < 5'(NS)) begin
      cir_r[cmd_idx] <= wdata_r[13:0];
    end
  end

  // Flow priority without regeneration or traffic class mapping.
  wire is_ip = pkt_ipv4 | pkt_ipv6;
  wire vlan_pri_ok = vlan_en & pkt_tagged;
  wire [2:0] ip_pri = (use_prec & pkt_ipv4) ? pkt_tos[7:5] : pkt_diffserv_pri;
  wire [2:0] port_def = def_pri[3 * pkt_port +: 3];
  wire [2:0] flow_pri =
    (vlan_pri_ok & (vlan_higher | ~(is_ip & use_ip))) ? pkt_vlan_pri :
    (is_ip & use_ip) ? ip_pri : port_def;
  // Stream selection by rate mode.
  wire [4:0] strm =
    (rate_mode_r == swip_pkg::SWIP_MODE_PRI) ? {2'h0, flow_pri} :
    (rate_mode_r == swip_pkg::SWIP_MODE_PORT_PRI) ? {pkt_port, flow_pri} :
    {3'h0, pkt_port};

  // Metering decision against the stream's buckets.
  wire meter_go = pkt_valid & rate_en_r;
  wire [15:0] len16 = {5'h0, pkt_len};
  wire is_green = cb_r[strm] >= len16;
  wire is_yellow = ~is_green & (eb_r[strm] >= len16);
  wire [1:0] color = ~rate_en_r ? swip_pkg::SWIP_GREEN :
    is_green ? swip_pkg::SWIP_GREEN :
    is_yellow ? swip_pkg::SWIP_YELLOW : swip_pkg::SWIP_RED;
  wire red_drop = rate_en_r & (color == swip_pkg::SWIP_RED);

  // Token buckets, one pair per stream.
  for (genvar g = 0; g < NS; g++) begin : g_strm
    wire [13:0] cir_eff = (cir_r[g] < swip_pkg::SWIP_CIR_MIN) ? swip_pkg::SWIP_CIR_MIN : cir_r[g];
    wire [14:0] reload = 15'(({1'b0, cir_eff} + 15'h0001) * swip_pkg::SWIP_STEP_CYC - 1);
    wire tick = tmr_r[g] == 15'h0;
    wire cb_add = tick & (cb_r[g] < cbs_r);
    wire eb_add = tick & (cb_r[g] >= cbs_r) & (eb_r[g] < ebs_r);
    wire hit = meter_go & (strm == 5'(g));
    wire [15:0] cb_sub = (hit & is_green) ? len16 : 16'h0;
    wire [15:0] eb_sub = (hit & is_yellow) ? len16 : 16'h0;
    always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
        tmr_r[g] <= 15'h0;
        cb_r[g] <= swip_pkg::SWIP_BUCKET_RST;
        eb_r[g] <= swip_pkg::SWIP_BUCKET_RST;
      end else begin
        tmr_r[g] <= tick ? reload : tmr_r[g] - 15'h0001;
        cb_r[g] <= cb_r[g] + {15'h0, cb_add} - cb_sub;
        eb_r[g] <= eb_r[g] + {15'h0, eb_add} - eb_sub;
      end
    end
  end

  // Broadcast throttle window and per-port byte counters.
  wire win_end = win_r == 18'(BCAST_WIN_CYC - 1);
  wire [15:0] bc_sum = bc_cnt_r[pkt_port] + len16;
  wire [15:0] bc_lim = {bc_lvl_r[8 * pkt_port +: 8], 8'h0} >> (8 - swip_pkg::SWIP_BC_UNIT_SH);
  wire bc_drop = pkt_bcast & bc_en_r[pkt_port] & (bc_sum > bc_lim);
  wire bc_count = pkt_valid & pkt_bcast & ~bc_drop;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      win_r <= 18'h0;
      for (int i = 0; i < 3; i++) begin
        bc_cnt_r[i] <= 16'h0;
      end
    end else begin
      win_r <= win_end ? 18'h0 : win_r + 18'h00001;
      for (int i = 0; i < 3; i++) begin
        if (win_end) begin
          bc_cnt_r[i] <= 16'h0;
        end else if (bc_count && pkt_port == 2'(i)) begin
          bc_cnt_r[i] <= bc_sum;
        end
      end
    end
  end

  // Multi-destination buffer cap.
  wire cap_drop = pkt_multi & (bcast_buf_used >= bc_cap_r);

  // IGMP trap and the filters that still apply to it.
  wire trap = igmp_en & pkt_ipv4 & pkt_mcast & (pkt_ip_proto == swip_pkg::SWIP_IGMP_PROTO);
  wire untag_or_pri = ~pkt_tagged | (pkt_vid == 12'h000);
  wire trap_filt_st = ~port_forwarding[pkt_port] & ~state_ovr;
  wire trap_filt_av = vlan_en & untag_or_pri & admit_only_vlan[pkt_port];
  wire trap_filt_vid = vlan_en & pkt_tagged & (pkt_vid == swip_pkg::SWIP_VID_RSVD);
  wire trap_filt_mem = vlan_en & mem_check & ~admit_nonmem & ~pkt_member;
  wire trap_filt = trap_filt_st | trap_filt_av | trap_filt_vid | trap_filt_mem;
  wire base_filt = trap ? trap_filt : pkt_filtered;
  // Red is discarded at ingress.
  wire drop = base_filt | bc_drop | cap_drop | red_drop;

  // Forwarding mask, source removal and mirroring.
  wire [2:0] src_m = 3'h1 << pkt_port;
  wire [2:0] snf_m = 3'h1 << sniffer;
  wire [2:0] mon_m = 3'h1 << mon_port;
  wire keep_src = trap & igmp_echo;
  wire [2:0] fwd = drop ? 3'h0 : (trap ? mon_m : pkt_dest);
  wire rx_mir = rx_mir_en & mirrored[pkt_port] & ((|fwd) | (drop & mir_filt_en));
  wire tx_mir = tx_mir_en & (|(fwd & mirrored));
  wire [2:0] out_m = fwd | ((rx_mir | tx_mir) ? snf_m : 3'h0);
  wire [2:0] dest = keep_src ? (fwd | (out_m & ~src_m)) : (out_m & ~src_m);

  // Decision register towards the buffer manager.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dec_valid_r <= 1'b0;
      dec_dest_r <= 3'h0;
      dec_drop_r <= 1'b0;
      dec_color_r <= swip_pkg::SWIP_GREEN;
      dec_stream_r <= 5'h0;
      dec_rnd_r <= 1'b0;
    end else begin
      dec_valid_r <= pkt_valid;
      if (pkt_valid) begin
        dec_dest_r <= dest;
        dec_drop_r <= drop;
        dec_color_r <= color;
        dec_stream_r <= strm;
        dec_rnd_r <= (color == swip_pkg::SWIP_YELLOW) & drop_yel;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign dec_valid = dec_valid_r;
  assign dec_dest = dec_dest_r;
  assign dec_drop = dec_drop_r;
  assign dec_color = dec_color_r;
  assign dec_stream = dec_stream_r;
  assign dec_rnd_discard = dec_rnd_r;

  // Checks.
  default clocking cb_chk @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  sequence s_pkt;
    pkt_valid ##1 dec_valid_r;
  endsequence

  property p_apb_wait;
    apb_setup |=> pready_r ##1 !pready_r;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("APB answer timing wrong.");

  property p_unmetered;
    pkt_valid && !rate_en_r |-> s_pkt ##0 dec_color_r == swip_pkg::SWIP_GREEN;
  endproperty
  a_unmetered: assert property (p_unmetered) else $error("Unmetered packet colored.");

  property p_green;
    meter_go && is_green |=> dec_color_r == swip_pkg::SWIP_GREEN
      && cb_r[dec_stream_r] <= $past(cb_r[strm]) - $past(len16) + 16'h0001;
  endproperty
  a_green: assert property (p_green) else $error("Green debit missing.");

  property p_yellow;
    dec_valid_r && dec_color_r == swip_pkg::SWIP_YELLOW |-> dec_rnd_r == drop_yel;
  endproperty
  a_yellow: assert property (p_yellow) else $error("Yellow discard mark wrong.");

  property p_red;
    meter_go && !is_green && !is_yellow |=> dec_drop_r && dec_dest_r == 3'h0
      || dec_color_r == swip_pkg::SWIP_RED && dec_drop_r;
  endproperty
  a_red: assert property (p_red) else $error("Red packet not dropped.");

  property p_throttle;
    pkt_valid && bc_drop |=> dec_drop_r;
  endproperty
  a_throttle: assert property (p_throttle) else $error("Broadcast over limit passed.");

  property p_cap;
    pkt_valid && pkt_multi && bcast_buf_used >= bc_cap_r |=> dec_drop_r;
  endproperty
  a_cap: assert property (p_cap) else $error("Buffer cap not enforced.");

  property p_trap;
    pkt_valid && trap && !drop && (igmp_echo || mon_port != pkt_port)
      |=> dec_dest_r[$past(mon_port)];
  endproperty
  a_trap: assert property (p_trap) else $error("IGMP packet not trapped.");

  property p_no_echo;
    pkt_valid && !keep_src |=> (dec_dest_r & $past(src_m)) == 3'h0;
  endproperty
  a_no_echo: assert property (p_no_echo) else $error("Packet sent to its source.");
endmodule // swip_policer

//--- test/swip_bm_model.sv
// Purpose: Buffer manager side model for the ingress policing bench.
// Assumes: Occupancy level and port states are set by the bench.
// Notes: Levels are registered, as a real buffer count would be.
`timescale 1ns/1ps
module swip_bm_model (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic nrst,
  // Decisions from the policer.
  input wire logic dec_valid,
  input wire logic dec_drop,
  // Bench settings.
  input wire logic [9:0] level_in,
  input wire logic [2:0] fwd_in,
  // Switch state toward the policer.
  output logic [9:0] bcast_buf_used,
  output logic [2:0] port_forwarding,
  output logic [15:0] accepted
);
  // Keeps occupancy and spanning tree state, counts packets taken in.
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      bcast_buf_used <= 10'h000;
      port_forwarding <= 3'h7;
      accepted <= 16'h0000;
    end else begin
      bcast_buf_used <= level_in;
      port_forwarding <= fwd_in;
      if (dec_valid && !dec_drop) begin
        accepted <= accepted + 16'h0001;
      end
    end
  end
endmodule // swip_bm_model

//--- test/switch_ingress_policing_tb.sv
// Purpose: Self-checking bench for the switch ingress policing block.
// Assumes: Zero-wait APB slave, decisions one cycle after each packet.
// Notes: Broadcast window shortened to 400 cycles.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin mismatches++; \
  $display("unexpected %s exp=%0h got=%0h", nm, ex, got); end end
module switch_ingress_policing_tb;
  typedef struct packed {logic [2:0] d; logic dr; logic [1:0] c; logic [4:0] s;
    logic m; logic r;} swip_exp_s;
  localparam int WIN = 400;
  localparam logic [1:0] GR = swip_pkg::SWIP_GREEN;
  localparam logic [1:0] YE = swip_pkg::SWIP_YELLOW;
  localparam logic [1:0] RD = swip_pkg::SWIP_RED;
  logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rs;
  logic pkt_valid, pkt_filtered, pkt_bcast, pkt_multi, pkt_mcast, pkt_ipv4, pkt_ipv6;
  logic pkt_tagged, pkt_member, dec_valid, dec_drop, dec_rnd_discard, rnd_on;
  logic [1:0] pkt_port, dec_color;
  logic [10:0] pkt_len;
  logic [2:0] pkt_dest, pkt_diffserv_pri, pkt_vlan_pri, port_forwarding, dec_dest, fwd_in;
  logic [7:0] pkt_ip_proto, pkt_tos;
  logic [11:0] pkt_vid;
  logic [9:0] bcast_buf_used, level_in;
  logic [4:0] dec_stream;
  int mismatches, checks, cyc;
  swip_exp_s q[$];
  swip_exp_s e;
  swip_policer #(.BCAST_WIN_CYC(WIN)) uut (.ref_clk(ref_clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pkt_valid(pkt_valid), .pkt_port(pkt_port),
    .pkt_len(pkt_len), .pkt_dest(pkt_dest), .pkt_filtered(pkt_filtered),
    .pkt_bcast(pkt_bcast), .pkt_multi(pkt_multi), .pkt_mcast(pkt_mcast),
    .pkt_ipv4(pkt_ipv4), .pkt_ipv6(pkt_ipv6), .pkt_ip_proto(pkt_ip_proto),
    .pkt_tos(pkt_tos), .pkt_diffserv_pri(pkt_diffserv_pri), .pkt_tagged(pkt_tagged),
    .pkt_vid(pkt_vid), .pkt_vlan_pri(pkt_vlan_pri), .pkt_member(pkt_member),
    .port_forwarding(port_forwarding), .bcast_buf_used(bcast_buf_used),
    .dec_valid(dec_valid), .dec_dest(dec_dest), .dec_drop(dec_drop),
    .dec_color(dec_color), .dec_stream(dec_stream), .dec_rnd_discard(dec_rnd_discard));
  swip_bm_model partner (.ref_clk(ref_clk), .nrst(nrst), .dec_valid(dec_valid),
    .dec_drop(dec_drop), .level_in(level_in), .fwd_in(fwd_in),
    .bcast_buf_used(bcast_buf_used), .port_forwarding(port_forwarding), .accepted());
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction
  task automatic summarize();
    $display("counts: checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rdat, output logic err);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      $display("unexpected pready exp=1 got=%0h", pready);
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Let one edge pass so the next call never re-drives psel in this time step.
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, d, x, er);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] ex, input logic exer);
    logic [31:0] x;
    logic er;
    apb(1'b0, a, 32'h0, x, er);
    `CHK("prdata", ex, x)
    `CHK("pslverr", exer, er)
  endtask
  // Flags: 0 filtered, 1 broadcast, 2 multi, 3 igmp, 4 other IPv4 multicast.
  task automatic send(input logic [1:0] p, input logic [10:0] l, input logic [2:0] d,
      input logic [4:0] f, input logic [2:0] ed, input logic edr, input logic [1:0] ec,
      input logic [4:0] es, input logic em);
    logic [31:0] r;
    r = rnd();
    pkt_valid <= 1'b1;
    pkt_port <= p;
    pkt_len <= l;
    pkt_dest <= d;
    pkt_filtered <= f[0];
    pkt_bcast <= f[1];
    pkt_multi <= f[2];
    pkt_ipv4 <= f[3] | f[4];
    pkt_mcast <= f[3] | f[4];
    pkt_ip_proto <= f[3] ? 8'h02 : 8'h03;
    pkt_ipv6 <= r[0];
    pkt_tos <= r[8:1];
    pkt_diffserv_pri <= r[11:9];
    pkt_tagged <= r[12];
    pkt_vid <= r[24:13];
    pkt_vlan_pri <= r[27:25];
    pkt_member <= r[28];
    q.push_back('{ed, edr, ec, es, em, rnd_on & (ec == YE)});
    @(posedge ref_clk);
  endtask
  task automatic idle(input int n);
    pkt_valid <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic done(input string s);
    idle(3);
    $display("test %s done", s);
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 8000) begin
      mismatches++;
      summarize();
    end
  end
  always @(posedge ref_clk) begin
    if (dec_valid === 1'b1) begin
      `CHK("queue", 1'b1, q.size() > 0)
      if (q.size() > 0) begin
        e = q.pop_front();
        `CHK("dec_dest", e.d, dec_dest)
        `CHK("dec_drop", e.dr, dec_drop)
        `CHK("dec_color", e.c, dec_color)
        `CHK("dec_rnd_discard", e.r, dec_rnd_discard)
        if (e.m) `CHK("dec_stream", e.s, dec_stream)
      end
    end
  end
  initial begin
    rs = 32'd41;
    {nrst, psel, penable, pwrite, pkt_valid, pkt_filtered, pkt_bcast, pkt_multi} = '0;
    {pkt_mcast, pkt_ipv4, pkt_ipv6, pkt_tagged, pkt_member, rnd_on} = '0;
    {pkt_port, pkt_len, pkt_dest, pkt_diffserv_pri, pkt_vlan_pri, pkt_ip_proto} = '0;
    {paddr, pwdata, pkt_tos, pkt_vid, level_in} = '0;
    fwd_in = 3'h7;
    mismatches = 0;
    checks = 0;
    cyc = 0;
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    rdchk(swip_pkg::SWIP_OFF_BC_CAP, 32'h0000_00FF, 1'b0);
    rdchk(swip_pkg::SWIP_OFF_RATE_CFG, 32'h0, 1'b0);
    rdchk(12'h040, 32'h0, 1'b1);
    wr(swip_pkg::SWIP_OFF_RATE_WDATA, 32'h0000_0005);
    rdchk(swip_pkg::SWIP_OFF_RATE_WDATA, 32'h0000_0005, 1'b0);
    wr(swip_pkg::SWIP_OFF_RATE_CMD, 32'h8000_0003);
    rdchk(swip_pkg::SWIP_OFF_RATE_CMD, 32'h0, 1'b0);
    done("registers");
    for (int i = 0; i < 12; i++) begin
      logic [31:0] r;
      logic [1:0] p;
      r = rnd();
      p = 2'(r[1:0] % 3);
      send(p, r[12:2] | 11'h400, r[15:13], 5'h0, r[15:13] & ~(3'h1 << p), 1'b0, GR,
        5'h0, 1'b0);
    end
    done("unmetered");
    wr(swip_pkg::SWIP_OFF_BUFFER_MANAGER_CONFIG_REG, 32'h2);
    rnd_on = 1'b1;
    wr(swip_pkg::SWIP_OFF_RATE_CFG, 32'h1);
    send(2'd1, 11'd1000, 3'b011, 5'h0, 3'b001, 1'b0, GR, 5'd1, 1'b1);
    send(2'd1, 11'd1000, 3'b011, 5'h0, 3'b001, 1'b0, YE, 5'd1, 1'b1);
    send(2'd1, 11'd1000, 3'b011, 5'h0, 3'b000, 1'b1, RD, 5'd1, 1'b1);
    idle(1);
    wr(swip_pkg::SWIP_OFF_GLB_CFG, 32'h0050_0000);
    wr(swip_pkg::SWIP_OFF_RATE_CFG, 32'h3);
    send(2'd2, 11'd1200, 3'b001, 5'h0, 3'b001, 1'b0, GR, 5'd5, 1'b1);
    idle(1);
    wr(swip_pkg::SWIP_OFF_RATE_CFG, 32'h5);
    send(2'd2, 11'd1200, 3'b001, 5'h0, 3'b001, 1'b0, GR, 5'd21, 1'b1);
    idle(1);
    wr(swip_pkg::SWIP_OFF_RATE_WDATA, 32'h0000_0064);
    wr(swip_pkg::SWIP_OFF_RATE_CMD, 32'h8000_0100);
    wr(swip_pkg::SWIP_OFF_RATE_WDATA, 32'h0000_0600);
    wr(swip_pkg::SWIP_OFF_RATE_CMD, 32'h8000_0200);
    send(2'd0, 11'd1200, 3'b010, 5'h0, 3'b010, 1'b0, GR, 5'd0, 1'b1);
    send(2'd0, 11'd400, 3'b010, 5'h0, 3'b010, 1'b0, YE, 5'd0, 1'b1);
    idle(1);
    wr(swip_pkg::SWIP_OFF_RATE_CFG, 32'h0);
    wr(swip_pkg::SWIP_OFF_BUFFER_MANAGER_CONFIG_REG, 32'h0);
    wr(swip_pkg::SWIP_OFF_GLB_CFG, 32'h0);
    rnd_on = 1'b0;
    done("metering");
    wr(swip_pkg::SWIP_OFF_BC_THROT, 32'h0100_0002);
    for (int n = 0; n < WIN && (cyc % WIN) != WIN / 2; n++) @(posedge ref_clk);
    send(2'd0, 11'd100, 3'b110, 5'h2, 3'b110, 1'b0, GR, 5'h0, 1'b0);
    send(2'd0, 11'd29, 3'b110, 5'h2, 3'b000, 1'b1, GR, 5'h0, 1'b0);
    send(2'd0, 11'd28, 3'b110, 5'h2, 3'b110, 1'b0, GR, 5'h0, 1'b0);
    idle(WIN);
    send(2'd0, 11'd120, 3'b110, 5'h2, 3'b110, 1'b0, GR, 5'h0, 1'b0);
    idle(1);
    wr(swip_pkg::SWIP_OFF_BC_THROT, 32'h0);
    done("throttle");
    wr(swip_pkg::SWIP_OFF_BC_CAP, 32'h0000_000A);
    level_in <= 10'd10;
    idle(3);
    send(2'd0, 11'd64, 3'b110, 5'h4, 3'b000, 1'b1, GR, 5'h0, 1'b0);
    level_in <= 10'd9;
    idle(3);
    send(2'd0, 11'd64, 3'b110, 5'h4, 3'b110, 1'b0, GR, 5'h0, 1'b0);
    done("cap");
    wr(swip_pkg::SWIP_OFF_GLB_CFG, 32'h1);
    send(2'd1, 11'd80, 3'b110, 5'h9, 3'b001, 1'b0, GR, 5'h0, 1'b0);
    send(2'd1, 11'd80, 3'b110, 5'h11, 3'b000, 1'b1, GR, 5'h0, 1'b0);
    fwd_in <= 3'b101;
    idle(3);
    send(2'd1, 11'd80, 3'b110, 5'h8, 3'b000, 1'b1, GR, 5'h0, 1'b0);
    fwd_in <= 3'h7;
    idle(1);
    wr(swip_pkg::SWIP_OFF_GLB_CFG, 32'h7);
    send(2'd1, 11'd80, 3'b100, 5'h8, 3'b010, 1'b0, GR, 5'h0, 1'b0);
    idle(1);
    wr(swip_pkg::SWIP_OFF_GLB_CFG, 32'h0);
    done("igmp");
    wr(swip_pkg::SWIP_OFF_MIRROR, 32'h11);
    send(2'd2, 11'd90, 3'b010, 5'h0, 3'b011, 1'b0, GR, 5'h0, 1'b0);
    send(2'd2, 11'd90, 3'b010, 5'h1, 3'b000, 1'b1, GR, 5'h0, 1'b0);
    idle(1);
    wr(swip_pkg::SWIP_OFF_MIRROR, 32'h91);
    send(2'd2, 11'd90, 3'b010, 5'h1, 3'b001, 1'b1, GR, 5'h0, 1'b0);
    idle(1);
    wr(swip_pkg::SWIP_OFF_MIRROR, 32'h12);
    send(2'd1, 11'd90, 3'b100, 5'h0, 3'b101, 1'b0, GR, 5'h0, 1'b0);
    idle(1);
    wr(swip_pkg::SWIP_OFF_MIRROR, 32'h51);
    send(2'd2, 11'd90, 3'b001, 5'h0, 3'b001, 1'b0, GR, 5'h0, 1'b0);
    done("mirror");
    `CHK("pending", 0, q.size())
    summarize();
  end
endmodule // switch_ingress_policing_tb
